// ### verilog/mcs_sequencer.sv
`include "mcs_defs.svh"

//Contract
//- flag interrupt when a voltage is above high or below low limit.
//- hot alarm sets above hot limit, clears at or below hysteresis.
//- start cycle on config write with run one and clear zero.
//- drive interrupt pin only while interrupt enable bit is one.
//- convert channels in fixed order, core voltage two first, temperature last.
//- store each finished conversion into its channel value register.
//- wrap to first channel and continue until run bit written zero.
//- step the channel counter every 22.5 kHz slot, seven slots per sequence.
//- start fan monitoring together with the analog sequence, then run independently.
//- 8-bit fan drive level register resets to all ones.
//- temperature result is 9-bit; top eight bits used for limits.
module mcs_sequencer
  import mcs_pkg::*;
#(
  parameter int unsigned SLOT_CYC = `MCS_SLOT_CYC
) (
  // clock and reset
  input  wire logic              MCLK_I,
  input  wire logic              NRST_I,
  // configuration register port
  input  wire logic              CFG_WR_I,
  input  wire mcs_pkg::mcs_byte_t CFG_WDATA_I,
  output mcs_pkg::mcs_byte_t     CFG_RDATA_O,
  // fan drive level register port
  input  wire logic              DRIVE_WR_I,
  input  wire mcs_pkg::mcs_byte_t DRIVE_WDATA_I,
  output mcs_pkg::mcs_byte_t     DRIVE_LEVEL_O,
  // converter
  output logic                   ADC_START_O,
  output mcs_pkg::mcs_chan_t     ADC_CHAN_O,
  input  wire logic              ADC_DONE_I,
  input  wire mcs_pkg::mcs_temp_t ADC_DATA_I,
  // limits
  input  wire mcs_pkg::mcs_byte_t VOLT_HIGH_LIMIT_I [`MCS_NUM_VOLT],
  input  wire mcs_pkg::mcs_byte_t VOLT_LOW_LIMIT_I  [`MCS_NUM_VOLT],
  input  wire mcs_pkg::mcs_byte_t HOT_LIMIT_I,
  input  wire mcs_pkg::mcs_byte_t HOT_HYST_LIMIT_I,
  // results and status
  output mcs_pkg::mcs_byte_t     VALUE_O [`MCS_NUM_CH],
  output logic                   TEMP_LSB_O,
  output logic [`MCS_NUM_VOLT-1:0] VOLT_ALARM_O,
  output logic                   HOT_ALARM_O,
  output logic                   FAN_START_O,
  // open-drain interrupt pin, low-active enable
  output logic                   INT_PIN_O,
  output logic                   INT_OE_N_O
);
  import mcs_pkg::*;

  mcs_byte_t  cfg_q;
  mcs_byte_t  drive_q;
  mcs_chan_t  chan_q;
  mcs_chan_t  chan_d;
  mcs_state_t state_q;
  mcs_state_t state_d;
  mcs_byte_t  value_q [`MCS_NUM_CH];
  logic       temp_lsb_q;
  logic [`MCS_NUM_VOLT-1:0] volt_alarm_q;
  logic       hot_q;
  logic       fan_start_q;
  logic       tick;

  wire run     = cfg_q[`MCS_CFG_RUN_BIT];
  wire int_en  = cfg_q[`MCS_CFG_INT_EN_BIT];
  wire int_clr = cfg_q[`MCS_CFG_INT_CLR_BIT];
  wire start_wr = CFG_WR_I && CFG_WDATA_I[`MCS_CFG_RUN_BIT]
                  && !CFG_WDATA_I[`MCS_CFG_INT_CLR_BIT];
  wire stop_wr  = CFG_WR_I && !CFG_WDATA_I[`MCS_CFG_RUN_BIT];
  wire kick     = start_wr && !run;
  wire store    = run && (state_q == MCS_WAIT_ADC) && ADC_DONE_I;
  wire conv_go  = run && (tick || state_q == MCS_IDLE) && !stop_wr;
  wire last_ch  = (chan_q == `MCS_LAST_CH);
  wire is_temp  = (chan_q == `MCS_TEMP_CH);
  wire [7:0] temp_top = ADC_DATA_I[8:1];
  wire hot_over  = $signed(temp_top) > $signed(HOT_LIMIT_I);
  wire hot_under = $signed(temp_top) <= $signed(HOT_HYST_LIMIT_I);

  mcs_slot_timer #(
    .SLOT_CYC (SLOT_CYC)
  ) u_slot (
    .clk_i     (MCLK_I),
    .nrst_i    (NRST_I),
    .restart_i (kick),
    .run_i     (run),
    .tick_o    (tick)
  );

  // channel steps once per slot and wraps after temperature
  assign chan_d = kick ? 3'h0 :
                  (tick && run) ? (last_ch ? 3'h0 : chan_q + 3'h1) :
                  chan_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      MCS_IDLE:      if (run) state_d = MCS_WAIT_ADC;
      MCS_WAIT_ADC:  if (ADC_DONE_I) state_d = MCS_WAIT_SLOT;
      MCS_WAIT_SLOT: if (tick) state_d = MCS_WAIT_ADC;
      default:       state_d = MCS_IDLE;
    endcase
    if (!run) begin
      state_d = MCS_IDLE;
    end
  end

  // conversion request is combinational; first slot fires right at start
  assign ADC_START_O = conv_go && (state_q != MCS_WAIT_ADC || tick);
  assign ADC_CHAN_O  = (state_q == MCS_IDLE) ? 3'h0 : chan_d;

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      cfg_q       <= `MCS_CFG_RESET;
      drive_q     <= `MCS_DRIVE_RESET;
      chan_q      <= 3'h0;
      state_q     <= MCS_IDLE;
      temp_lsb_q  <= 1'b0;
      hot_q       <= 1'b0;
      fan_start_q <= 1'b0;
    end else begin
      if (CFG_WR_I) begin
        cfg_q <= CFG_WDATA_I;
      end
      if (DRIVE_WR_I) begin
        drive_q <= DRIVE_WDATA_I;
      end
      chan_q      <= chan_d;
      state_q     <= state_d;
      fan_start_q <= kick;
      if (store && is_temp) begin
        temp_lsb_q <= ADC_DATA_I[0];
        // hysteresis: holds between the two limits
        if (hot_over) begin
          hot_q <= 1'b1;
        end else if (hot_under) begin
          hot_q <= 1'b0;
        end
      end
    end
  end

  generate
    for (genvar i = 0; i < `MCS_NUM_CH; i++) begin : g_val
      always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
          value_q[i] <= 8'h00;
        end else if (store && chan_q == 3'(i)) begin
          value_q[i] <= (i == `MCS_NUM_CH - 1) ? temp_top
                                               : ADC_DATA_I[7:0];
        end
      end
      assign VALUE_O[i] = value_q[i];
    end
    for (genvar v = 0; v < `MCS_NUM_VOLT; v++) begin : g_lim
      wire out_lim = (ADC_DATA_I[7:0] > VOLT_HIGH_LIMIT_I[v])
                  || (ADC_DATA_I[7:0] < VOLT_LOW_LIMIT_I[v]);
      wire set_v   = store && chan_q == 3'(v) && out_lim;
      // sticky until the clear bit is held; a new violation wins
      always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
          volt_alarm_q[v] <= 1'b0;
        end else if (set_v) begin
          volt_alarm_q[v] <= 1'b1;
        end else if (int_clr) begin
          volt_alarm_q[v] <= 1'b0;
        end
      end
    end
  endgenerate

  wire irq = (|volt_alarm_q) || hot_q;

  assign CFG_RDATA_O   = cfg_q;
  assign DRIVE_LEVEL_O = drive_q;
  assign TEMP_LSB_O    = temp_lsb_q;
  assign VOLT_ALARM_O  = volt_alarm_q;
  assign HOT_ALARM_O   = hot_q;
  assign FAN_START_O   = fan_start_q;
  assign INT_PIN_O     = 1'b0;
  // the clear bit also masks the pin so software can quiet it while clearing
  assign INT_OE_N_O    = !(irq && int_en && !int_clr);
endmodule

// ### verilog/mcs_defs.svh
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH

// configuration register fields
`define MCS_CFG_RUN_BIT      0
`define MCS_CFG_INT_EN_BIT   1
`define MCS_CFG_INT_CLR_BIT  3
`define MCS_CFG_RESET        8'h00

// fan drive level register
`define MCS_DRIVE_RESET      8'hFF

// sequence shape
`define MCS_NUM_CH           7
`define MCS_NUM_VOLT         6
`define MCS_TEMP_CH          3'h6
`define MCS_LAST_CH          3'h6

// timing
`define MCS_CLK_HZ           25000000
`define MCS_OSC_HZ           22500
`define MCS_SLOT_NS          44400
`define MCS_SLOT_CYC         (`MCS_CLK_HZ / `MCS_OSC_HZ)

`endif

// ### verilog/mcs_pkg.sv
`include "mcs_defs.svh"

package mcs_pkg;
  typedef logic [2:0] mcs_chan_t;
  typedef logic [7:0] mcs_byte_t;
  typedef logic [8:0] mcs_temp_t;
  typedef enum logic [1:0] {
    MCS_IDLE,
    MCS_WAIT_ADC,
    MCS_WAIT_SLOT
  } mcs_state_t;
endpackage

// ### verilog/mcs_slot_timer.sv
`include "mcs_defs.svh"

module mcs_slot_timer #(
  parameter int unsigned SLOT_CYC = `MCS_SLOT_CYC
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic restart_i,
  input  wire logic run_i,
  output logic      tick_o
);
  logic [12:0] cnt_q;
  logic [12:0] cnt_d;
  wire         wrap = (cnt_q == 13'(SLOT_CYC - 1));

  // restart preloads all ones: the first request goes out one cycle after
  // the start write, so the first slot would otherwise be one cycle short
  assign cnt_d  = restart_i ? 13'h1FFF :
                  (!run_i || wrap) ? 13'h0000 : cnt_q + 13'h0001;
  assign tick_o = run_i && wrap;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_q <= 13'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ### testbench/mcs_sequencer_checker.sv
`include "mcs_defs.svh"

module mcs_sequencer_checker
  import mcs_pkg::*;
#(
  parameter int unsigned SLOT_CYC = `MCS_SLOT_CYC
) (
  // clock, reset, strobes
  input wire logic      MCLK_I, NRST_I, CFG_WR_I, DRIVE_WR_I, ADC_DONE_I,
  input wire logic      ADC_START_O, FAN_START_O, INT_OE_N_O,
  // data
  input wire mcs_pkg::mcs_byte_t CFG_WDATA_I, CFG_RDATA_O, DRIVE_WDATA_I,
  input wire mcs_pkg::mcs_byte_t DRIVE_LEVEL_O, VALUE_O [`MCS_NUM_CH],
  input wire mcs_pkg::mcs_chan_t ADC_CHAN_O,
  input wire mcs_pkg::mcs_temp_t ADC_DATA_I
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);
  mcs_chan_t ch_q;
  logic      have_q;
  mcs_temp_t dat_q;
  // have_q drops while stopped, so the first request of a run is not compared for channel order
  always_ff @(posedge MCLK_I) begin
    dat_q <= ADC_DATA_I;
    have_q <= NRST_I && CFG_RDATA_O[0] && (have_q || ADC_START_O);
    if (ADC_START_O) ch_q <= ADC_CHAN_O;
  end
  chk_drive_reset: assert property ($rose(NRST_I) |-> DRIVE_LEVEL_O == 8'hFF)
    else $error("drive level not all ones after reset");
  chk_drive_write: assert property (DRIVE_WR_I |=> DRIVE_LEVEL_O == $past(DRIVE_WDATA_I))
    else $error("drive level write lost");
  chk_run_reset: assert property ($rose(NRST_I) |-> CFG_RDATA_O == 8'h00)
    else $error("config not clear after reset");
  chk_int_gate: assert property (!CFG_RDATA_O[1] || CFG_RDATA_O[3] |-> INT_OE_N_O)
    else $error("interrupt driven while disabled");
  chk_run_start: assert property (CFG_WR_I && CFG_WDATA_I[0] && !CFG_WDATA_I[3] && !CFG_RDATA_O[0]
    |=> FAN_START_O && ADC_START_O && ADC_CHAN_O == 3'h0) else $error("run start wrong");
  chk_idle_quiet: assert property (!CFG_RDATA_O[0] |-> !ADC_START_O)
    else $error("conversion while stopped");
  chk_chan_order: assert property (ADC_START_O && have_q
    |-> ADC_CHAN_O == ((ch_q == 3'h6) ? 3'h0 : ch_q + 3'h1)) else $error("channel order");
  chk_store_value: assert property (ADC_DONE_I && have_q && !CFG_WR_I |=>
    VALUE_O[ch_q] == ((ch_q == 3'h6) ? dat_q[8:1] : dat_q[7:0])) else $error("value not stored");
  cover property (FAN_START_O);
  cover property (!INT_OE_N_O);
  cover property (ADC_START_O && ADC_CHAN_O == 3'h6);
endmodule

bind mcs_sequencer mcs_sequencer_checker #(.SLOT_CYC(SLOT_CYC)) u_chk (.*);

// ### testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK_I = '0, NRST_I = '0, CFG_WR_I = '0, DRIVE_WR_I = '0, ADC_DONE_I = '0;
  logic [7:0] CFG_WDATA_I = '0, DRIVE_WDATA_I = '0, CFG_RDATA_O, DRIVE_LEVEL_O;
  logic [7:0] HOT_LIMIT_I = 8'h50, HOT_HYST_LIMIT_I = 8'h40, VALUE_O [7];
  logic [7:0] VOLT_HIGH_LIMIT_I [6] = '{default: 8'hC0};
  logic [7:0] VOLT_LOW_LIMIT_I [6] = '{default: 8'h10};
  logic [8:0] ADC_DATA_I = '0;
  logic [2:0] ADC_CHAN_O;
  logic [5:0] VOLT_ALARM_O;
  logic ADC_START_O, TEMP_LSB_O, HOT_ALARM_O, FAN_START_O, INT_PIN_O, INT_OE_N_O;
  int n_mismatch = 0, compares = 0;
  // short slot keeps the 21-conversion run small
  mcs_sequencer #(.SLOT_CYC(20)) DUT (.*);
  initial forever #20 MCLK_I = ~MCLK_I;
  task automatic chk(input logic [8:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cfg(input logic [7:0] d);
    @(posedge MCLK_I);
    CFG_WR_I <= 1'b1;
    CFG_WDATA_I <= d;
    @(posedge MCLK_I);
    CFG_WR_I <= 1'b0;
    @(negedge MCLK_I);
  endtask
  task automatic t_reset;
    @(negedge MCLK_I);
    chk(CFG_RDATA_O, 8'h00, "cfg");
    chk(DRIVE_LEVEL_O, 8'hFF, "drive");
    chk(INT_OE_N_O, 1'b1, "int_oe_n");
    chk(INT_PIN_O, 1'b0, "int_pin");
    repeat (30) @(negedge MCLK_I) chk(ADC_START_O, 1'b0, "start");
    @(posedge MCLK_I);
    DRIVE_WR_I <= 1'b1;
    DRIVE_WDATA_I <= 8'h5A;
    @(posedge MCLK_I);
    DRIVE_WR_I <= 1'b0;
    @(negedge MCLK_I);
    chk(DRIVE_LEVEL_O, 8'h5A, "drive");
    $display("t_reset done");
  endtask
  task automatic t_cycle;
    int n;
    time t0;
    logic [8:0] d;
    cfg(8'h03);
    chk(FAN_START_O, 1'b1, "fan_start");
    for (int i = 0; i < 21; i++) begin
      n = 0;
      while (!ADC_START_O && n < 100) begin
        @(negedge MCLK_I);
        n++;
      end
      chk(ADC_CHAN_O, 9'(i % 7), "chan");
      if (i > 0) chk(9'(($time - t0) / 40), 9'h014, "slot");
      t0 = $time;
      // ch2 above high, ch4 below low, ch1 sits on the low limit
      d = (i == 2) ? 9'h0D0 : (i == 11) ? 9'h00F : (i % 7 == 1) ? 9'h010 : 9'h040;
      if (i % 7 == 6) d = {(i == 6) ? 8'h51 : (i == 13) ? 8'h41 : 8'h40, i != 13};
      @(posedge MCLK_I);
      ADC_DONE_I <= 1'b1;
      ADC_DATA_I <= d;
      @(posedge MCLK_I);
      ADC_DONE_I <= 1'b0;
      @(negedge MCLK_I);
      chk(VALUE_O[i % 7], (i % 7 == 6) ? d[8:1] : d[7:0], "value");
      if (i % 7 == 6) chk(TEMP_LSB_O, d[0], "temp_lsb");
      if (i % 7 == 6) chk(HOT_ALARM_O, i != 20, "hot");
    end
    chk(VOLT_ALARM_O, 6'h14, "volt_alarm");
    chk(INT_OE_N_O, 1'b0, "int_oe_n");
    cfg(8'h01);
    chk(INT_OE_N_O, 1'b1, "int_oe_n");
    cfg(8'h0A);
    chk(INT_OE_N_O, 1'b1, "int_oe_n");
    // the clear bit acts from the stored config, one edge after the write
    @(negedge MCLK_I);
    chk(VOLT_ALARM_O, 6'h00, "volt_alarm");
    repeat (50) @(negedge MCLK_I) chk(ADC_START_O, 1'b0, "start");
    $display("t_cycle done");
  endtask
  initial begin
    repeat (4) @(posedge MCLK_I);
    NRST_I <= 1'b1;
    t_reset;
    t_cycle;
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge MCLK_I);
    n_mismatch++;
    end_sim;
  end
endmodule
